// *** sdp_pkg.sv ***
// Package: register map, field layout, reset values and carrier types of the divider/power-down bank
package sdp_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SYNTH = 6'h19;
  localparam logic [5:0] IDX_VCO = 6'h1a;
  localparam logic [5:0] IDX_REF = 6'h1b;
  localparam logic [5:0] IDX_RSVA = 6'h1c;
  localparam logic [5:0] IDX_RSVB = 6'h1d;
  localparam logic [5:0] IDX_MULT = 6'h30;
  // Values after reset
  localparam logic [15:0] RST_SYNTH = 16'h0440;
  localparam logic [15:0] RST_VCO = 16'h0020;
  localparam logic [15:0] RST_REF = 16'h0000;
  localparam logic [15:0] RST_MULT = 16'h0000;
  // Writable bits; all others hold their reset value
  localparam logic [15:0] MASK_SYNTH = 16'hfffc;
  localparam logic [15:0] MASK_VCO = 16'hfcf0;
  localparam logic [15:0] MASK_REF = 16'h8800;
  localparam logic [15:0] MASK_MULT = 16'h0400;
  // Field positions
  localparam int FB_MODE = 15;
  localparam int FB_MSB = 14;
  localparam int FB_LSB = 8;
  localparam int RDIV_MSB = 7;
  localparam int RDIV_LSB = 4;
  localparam int BTUNE_MSB = 3;
  localparam int BTUNE_LSB = 2;
  localparam int COARSE_MSB = 15;
  localparam int COARSE_LSB = 10;
  localparam int BIAS_SLP = 7;
  localparam int TSENSE_SLP = 6;
  localparam int MULT_SLP = 5;
  localparam int CLKRX_SLP = 4;
  localparam int EXTREF = 15;
  localparam int FUSE_SLP = 11;
  localparam int MULT_EN = 10;
  // Smallest legal feedback code in the low seven bits
  localparam logic [6:0] FB_MIN_CODE = 7'h04;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_ACK = 2'b10
  } sdp_phase_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } sdp_avs_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } sdp_avs_rsp_t;

  typedef struct packed {
    logic [7:0] fb_div;
    logic fb_div_ok;
    logic [4:0] ref_div;
    logic [1:0] vco_bias_tune;
    logic [5:0] vco_coarse;
    logic bias_sleep;
    logic tsense_sleep;
    logic mult_sleep;
    logic clkrx_sleep;
    logic output_strobe_input_sleep;
    logic extref_sel;
    logic fuse_sleep;
    logic mult_route;
  } sdp_analog_t;
endpackage

// *** sdp_regs.sv ***
// Top: Avalon-MM register bank driving divider, tuning and power-down controls
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
// Behaviour
// - Feedback mode bit clear: divide by low seven bits, 4..127 valid.
// - Feedback mode bit set: divide by twice low seven bits, 8..254.
// - Feedback divider field in bits 15:8, reset pattern 00000100.
// - Reference divider bits 7:4 divide by code plus one.
// - Coarse tuning field bits 15:10 writable, resets to zero.
// - Bit 7 of power register sleeps the bias amplifier; resets zero.
// - Bit 6 of power register turns off temperature sensor; resets zero.
// - Bit 5 of power register sleeps multiplier; resets one.
// - Bit 4 sleeps clock receiver and output strobe receiver.
// - Reference bit 15 selects internal (0) or external (1); resets internal.
// - Multiplier enable bit 10 routes clock through multiplier, else bypass.
module sdp_regs
  import sdp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire sdp_avs_req_t avs_req,
  output sdp_avs_rsp_t avs_rsp,
  // Analog control outputs
  output sdp_analog_t ana
);

  typedef struct packed {
    sdp_phase_t phase;
    logic [15:0] synth;
    logic [15:0] vco;
    logic [15:0] refr;
    logic [15:0] mult;
    sdp_avs_rsp_t rsp;
    sdp_analog_t ana;
  } sdp_state_t;

  sdp_state_t s_r;
  sdp_state_t s_nxt;
  logic [5:0] idx;
  logic req_any;
  logic req_go;
  logic wr_go;

  // Feedback divide value; both modes share the same legal low-code bound
  function automatic logic [7:0] fb_val(input logic [15:0] r);
    if (r[FB_MODE]) begin
      fb_val = {r[FB_MSB:FB_LSB], 1'b0};
    end else begin
      fb_val = {1'b0, r[FB_MSB:FB_LSB]};
    end
  endfunction

  // Codes 0..3 are illegal in either mode
  function automatic logic fb_ok(input logic [15:0] r);
    fb_ok = (r[FB_MSB:FB_LSB] >= FB_MIN_CODE);
  endfunction

  function automatic logic [4:0] ref_val(input logic [15:0] r);
    ref_val = {1'b0, r[RDIV_MSB:RDIV_LSB]} + 5'h01;
  endfunction

  // Byte-lane merge; bits outside the mask keep their reset value
  function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [15:0] mask,
                                           input logic [15:0] rst);
    logic [15:0] lanes;
    logic [15:0] merged;
    lanes = {{8{be[1]}}, {8{be[0]}}};
    merged = (wd[15:0] & lanes) | (old & ~lanes);
    wr_merge = (merged & mask) | (rst & ~mask);
  endfunction

  function automatic logic [15:0] rd_word(input sdp_state_t s, input logic [5:0] i);
    if (i == IDX_SYNTH) begin
      rd_word = s.synth;
    end else if (i == IDX_VCO) begin
      rd_word = s.vco;
    end else if (i == IDX_REF) begin
      rd_word = s.refr;
    end else if (i == IDX_MULT) begin
      rd_word = s.mult;
    end else begin
      rd_word = 16'h0000;
    end
  endfunction

  assign idx = avs_req.address[7:2];
  assign req_any = avs_req.read | avs_req.write;
  assign req_go = req_any && (s_r.phase == PH_IDLE);
  // Write lands at the edge where waitrequest is seen low
  assign wr_go = avs_req.write && (s_r.phase == PH_ACK);

  // Next state: bus handshake, register writes and analog decode
  always_comb begin
    s_nxt = s_r;
    case (s_r.phase)
      PH_IDLE: begin
        if (req_go) begin
          s_nxt.phase = PH_ACK;
        end
      end
      PH_ACK: begin
        s_nxt.phase = PH_IDLE;
      end
      default: begin
        s_nxt.phase = PH_IDLE;
      end
    endcase
    // One wait state, so read data is captured before it is shown
    s_nxt.rsp.waitrequest = (s_nxt.phase != PH_ACK);
    if (req_go && avs_req.read) begin
      s_nxt.rsp.readdata = {16'h0000, rd_word(s_r, idx)};
    end else if (s_r.phase == PH_ACK) begin
      s_nxt.rsp.readdata = s_r.rsp.readdata;
    end else begin
      s_nxt.rsp.readdata = 32'h0000_0000;
    end
    // Register writes; unmapped and reserved indices are ignored
    if (wr_go) begin
      if (idx == IDX_SYNTH) begin
        s_nxt.synth = wr_merge(s_r.synth, avs_req.writedata, avs_req.byteenable,
                               MASK_SYNTH, RST_SYNTH);
      end else if (idx == IDX_VCO) begin
        s_nxt.vco = wr_merge(s_r.vco, avs_req.writedata, avs_req.byteenable,
                             MASK_VCO, RST_VCO);
      end else if (idx == IDX_REF) begin
        s_nxt.refr = wr_merge(s_r.refr, avs_req.writedata, avs_req.byteenable,
                              MASK_REF, RST_REF);
      end else if (idx == IDX_MULT) begin
        s_nxt.mult = wr_merge(s_r.mult, avs_req.writedata, avs_req.byteenable,
                              MASK_MULT, RST_MULT);
      end
    end
    // Decoded controls follow the registers one cycle later
    s_nxt.ana.fb_div = fb_val(s_r.synth);
    s_nxt.ana.fb_div_ok = fb_ok(s_r.synth);
    s_nxt.ana.ref_div = ref_val(s_r.synth);
    s_nxt.ana.vco_bias_tune = s_r.synth[BTUNE_MSB:BTUNE_LSB];
    s_nxt.ana.vco_coarse = s_r.vco[COARSE_MSB:COARSE_LSB];
    s_nxt.ana.bias_sleep = s_r.vco[BIAS_SLP];
    s_nxt.ana.tsense_sleep = s_r.vco[TSENSE_SLP];
    s_nxt.ana.mult_sleep = s_r.vco[MULT_SLP];
    s_nxt.ana.clkrx_sleep = s_r.vco[CLKRX_SLP];
    s_nxt.ana.output_strobe_input_sleep = s_r.vco[CLKRX_SLP];
    s_nxt.ana.extref_sel = s_r.refr[EXTREF];
    s_nxt.ana.fuse_sleep = s_r.refr[FUSE_SLP];
    // Bypass unless enabled; enable alone does not wake the multiplier
    s_nxt.ana.mult_route = s_r.mult[MULT_EN];
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r.phase <= PH_IDLE;
      s_r.synth <= RST_SYNTH;
      s_r.vco <= RST_VCO;
      s_r.refr <= RST_REF;
      s_r.mult <= RST_MULT;
      s_r.rsp.waitrequest <= 1'b1;
      s_r.rsp.readdata <= 32'h0000_0000;
      s_r.ana.fb_div <= fb_val(RST_SYNTH);
      s_r.ana.fb_div_ok <= fb_ok(RST_SYNTH);
      s_r.ana.ref_div <= ref_val(RST_SYNTH);
      s_r.ana.vco_bias_tune <= RST_SYNTH[BTUNE_MSB:BTUNE_LSB];
      s_r.ana.vco_coarse <= RST_VCO[COARSE_MSB:COARSE_LSB];
      s_r.ana.bias_sleep <= RST_VCO[BIAS_SLP];
      s_r.ana.tsense_sleep <= RST_VCO[TSENSE_SLP];
      s_r.ana.mult_sleep <= RST_VCO[MULT_SLP];
      s_r.ana.clkrx_sleep <= RST_VCO[CLKRX_SLP];
      s_r.ana.output_strobe_input_sleep <= RST_VCO[CLKRX_SLP];
      s_r.ana.extref_sel <= RST_REF[EXTREF];
      s_r.ana.fuse_sleep <= RST_REF[FUSE_SLP];
      s_r.ana.mult_route <= RST_MULT[MULT_EN];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_rsp = s_r.rsp;
  assign ana = s_r.ana;

  // Checks on decode, power bits, reserved bits and the bus handshake
  a_fb_direct_mode: assert property (@(posedge clk) disable iff (!reset_n)
    !s_r.synth[FB_MODE] |=> (ana.fb_div[7] == 1'b0) && (ana.fb_div[6:0] == $past(s_r.synth[FB_MSB:FB_LSB])))
    else $error("direct feedback value wrong");
  a_fb_double_mode: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.synth[FB_MODE] |=> (ana.fb_div[0] == 1'b0) && (ana.fb_div[7:1] == $past(s_r.synth[FB_MSB:FB_LSB])))
    else $error("doubled feedback value wrong");
  a_fb_code_ok: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.synth[FB_MSB:FB_LSB] < FB_MIN_CODE) |=> !ana.fb_div_ok)
    else $error("illegal feedback code flagged ok");
  a_fb_reset_val: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> (s_r.synth == RST_SYNTH) ##1 (ana.fb_div == 8'h04))
    else $error("feedback reset value wrong");
  a_ref_div_plus: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.ref_div == ({1'b0, $past(s_r.synth[RDIV_MSB:RDIV_LSB])} + 5'h01)))
    else $error("reference divide not code plus one");
  a_coarse_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_go && idx == IDX_VCO && avs_req.byteenable[1])
    |=> (s_r.vco[COARSE_MSB:COARSE_LSB] == $past(avs_req.writedata[15:10])) ##1
        (ana.vco_coarse == $past(avs_req.writedata[15:10], 2)))
    else $error("coarse tuning write lost");
  a_bias_sleep: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.bias_sleep == $past(s_r.vco[BIAS_SLP])))
    else $error("bias sleep not following register");
  a_tsense_off: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(s_r.vco[TSENSE_SLP]) |=> ana.tsense_sleep)
    else $error("temperature sensor not off");
  a_mult_sleep_rst: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> ana.mult_sleep && s_r.vco[MULT_SLP])
    else $error("multiplier not asleep after reset");
  a_clkrx_both: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 ((ana.clkrx_sleep == $past(s_r.vco[CLKRX_SLP]))
    && (ana.output_strobe_input_sleep == $past(s_r.vco[CLKRX_SLP]))))
    else $error("strobe receiver sleep differs from clock receiver");
  a_extref_sel: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.extref_sel == $past(s_r.refr[EXTREF])))
    else $error("reference select wrong");
  a_mult_route: assert property (@(posedge clk) disable iff (!reset_n)
    !s_r.mult[MULT_EN] |=> !ana.mult_route)
    else $error("multiplier not bypassed");
  a_rsvd_hold: assert property (@(posedge clk) disable iff (!reset_n)
    ((s_r.synth & ~MASK_SYNTH) == (RST_SYNTH & ~MASK_SYNTH)) && ((s_r.vco & ~MASK_VCO) == (RST_VCO & ~MASK_VCO))
    && ((s_r.refr & ~MASK_REF) == (RST_REF & ~MASK_REF)))
    else $error("reserved bits changed");
  a_rsvd_read: assert property (@(posedge clk) disable iff (!reset_n)
    (req_go && avs_req.read && (idx == IDX_RSVA || idx == IDX_RSVB)) |=> (avs_rsp.readdata == 32'h0000_0000))
    else $error("reserved register reads nonzero");
  a_wait_one: assert property (@(posedge clk) disable iff (!reset_n)
    req_go |=> !avs_rsp.waitrequest ##1 avs_rsp.waitrequest)
    else $error("waitrequest not low for one cycle");
  // Field placement, follow-through of the tuning, sensor, multiplier, fuse and feedback-ok controls, and the bus rules
  a_fb_ok_legal: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.synth[FB_MSB:FB_LSB] >= FB_MIN_CODE) |=> ana.fb_div_ok)
    else $error("legal feedback code flagged bad");
  a_fb_field_pos: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_go && idx == IDX_SYNTH && avs_req.byteenable[1]) |=> (s_r.synth[FB_MODE:FB_LSB] == $past(avs_req.writedata[15:8])))
    else $error("feedback field not in upper byte");
  a_ref_div_field: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_go && idx == IDX_SYNTH && avs_req.byteenable[0])
    |=> (s_r.synth[RDIV_MSB:RDIV_LSB] == $past(avs_req.writedata[RDIV_MSB:RDIV_LSB])))
    else $error("reference divider field write lost");
  a_ref_div_range: assert property (@(posedge clk) disable iff (!reset_n)
    (ana.ref_div >= 5'h01) && (ana.ref_div <= 5'h10))
    else $error("reference divide out of range");
  a_bias_tune_out: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.vco_bias_tune == $past(s_r.synth[BTUNE_MSB:BTUNE_LSB])))
    else $error("bias tuning not following register");
  a_coarse_follow: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.vco_coarse == $past(s_r.vco[COARSE_MSB:COARSE_LSB])))
    else $error("coarse tuning not following register");
  a_coarse_reset: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> (ana.vco_coarse == 6'h00) && (s_r.vco[COARSE_MSB:COARSE_LSB] == 6'h00))
    else $error("coarse tuning not zero after reset");
  a_power_reset: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !ana.bias_sleep && !ana.tsense_sleep
    && !ana.clkrx_sleep && !ana.output_strobe_input_sleep)
    else $error("power-down bit set after reset");
  a_tsense_follow: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.tsense_sleep == $past(s_r.vco[TSENSE_SLP])))
    else $error("temperature sensor control not following register");
  a_mult_sleep_follow: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.mult_sleep == $past(s_r.vco[MULT_SLP])))
    else $error("multiplier sleep not following register");
  a_extref_reset: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !ana.extref_sel && !ana.fuse_sleep)
    else $error("reference or fuse control set after reset");
  a_fuse_follow: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (ana.fuse_sleep == $past(s_r.refr[FUSE_SLP])))
    else $error("fuse sleep not following register");
  a_mult_enable: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.mult[MULT_EN] |=> ana.mult_route)
    else $error("multiplier not in the clock path");
  a_mult_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.mult & ~MASK_MULT) == (RST_MULT & ~MASK_MULT))
    else $error("reserved multiplier control bits changed");
  a_rsvd_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_go && (idx == IDX_RSVA || idx == IDX_RSVB))
    |=> (s_r.synth == $past(s_r.synth)) && (s_r.vco == $past(s_r.vco)) && (s_r.refr == $past(s_r.refr)))
    else $error("reserved register write changed state");
  a_ref_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_go && idx == IDX_REF && avs_req.byteenable[1:0] == 2'b11)
    |=> (s_r.refr == (($past(avs_req.writedata[15:0]) & MASK_REF) | (RST_REF & ~MASK_REF))))
    else $error("reference register write wrong");
  a_regs_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !wr_go |=> $stable(s_r.synth) && $stable(s_r.vco) && $stable(s_r.refr) && $stable(s_r.mult))
    else $error("register changed without a write");
  a_read_data: assert property (@(posedge clk) disable iff (!reset_n)
    (req_go && avs_req.read && idx == IDX_SYNTH) |=> (avs_rsp.readdata == {16'h0000, $past(s_r.synth)}))
    else $error("read data not the register contents");
  a_rdata_upper: assert property (@(posedge clk) disable iff (!reset_n)
    avs_rsp.readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_wait_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.phase == PH_IDLE) |-> avs_rsp.waitrequest)
    else $error("waitrequest low while idle");
  a_ack_release: assert property (@(posedge clk) disable iff (!reset_n)
    !avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("waitrequest low for two cycles");

  c_synth_write: cover property (@(posedge clk) disable iff (!reset_n) wr_go && idx == IDX_SYNTH);
  c_vco_read: cover property (@(posedge clk) disable iff (!reset_n) req_go && avs_req.read && idx == IDX_VCO);
  c_fb_double: cover property (@(posedge clk) disable iff (!reset_n) ana.fb_div_ok && s_r.synth[FB_MODE]);
  c_back_to_back: cover property (@(posedge clk) disable iff (!reset_n) wr_go ##1 req_go);
  c_rsvd_read: cover property (@(posedge clk) disable iff (!reset_n) req_go && avs_req.read && idx == IDX_RSVA);
endmodule

// *** sdp_regs_tb_top.sv ***
// Testbench: Avalon-driven checks of the divider, tuning and power-down register bank
`timescale 1ns/10ps
module sdp_regs_tb_top;
  import sdp_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  sdp_avs_req_t req = '0;
  sdp_avs_rsp_t rsp;
  sdp_analog_t ana;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] rd;

  // 20 MHz clock
  always #25 clk = ~clk;

  sdp_regs i_dut (.clk(clk), .reset_n(reset_n), .avs_req(req), .avs_rsp(rsp), .ana(ana));

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access; the request stands until waitrequest is seen low at an edge, then is released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= {16'h0000, d};
    req.byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (rsp.waitrequest !== 1'b0) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 4'h3);
    cmp(rd, {16'h0000, exp});
  endtask

  // Outputs trail a write by one clock; let them land before looking
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic reset_values();
    rchk(8'h64, 16'h0440);
    rchk(8'h68, 16'h0020);
    rchk(8'h6c, 16'h0000);
    rchk(8'hc0, 16'h0000);
    cmp(32'(ana.fb_div), 32'h0000_0004);
    cmp(32'(ana.fb_div_ok), 32'h0000_0001);
    cmp(32'(ana.ref_div), 32'h0000_0005);
    cmp(32'({ana.bias_sleep, ana.tsense_sleep, ana.mult_sleep, ana.clkrx_sleep}), 32'h0000_0002);
    cmp(32'({ana.extref_sel, ana.fuse_sleep, ana.mult_route, ana.vco_coarse}), 32'h0000_0000);
  endtask

  // Feedback divider in both modes, including codes below the legal floor
  task automatic feedback_modes();
    logic [15:0] d[6] = '{16'h7f04, 16'h0404, 16'h0304, 16'h8404, 16'hffff, 16'h8304};
    logic [7:0] f[6] = '{8'd127, 8'd4, 8'd0, 8'd8, 8'd254, 8'd0};
    for (int i = 0; i < 6; i++) begin
      wr(8'h64, d[i]);
      rchk(8'h64, d[i] & 16'hfffc);
      settle();
      cmp(32'(ana.fb_div_ok), {31'h0, f[i] != 8'd0});
      if (f[i] != 8'd0) begin
        cmp(32'(ana.fb_div), {24'h0, f[i]});
      end
      cmp(32'(ana.vco_bias_tune), {30'h0, d[i][3:2]});
    end
  endtask

  task automatic ref_divider();
    for (int c = 0; c < 16; c++) begin
      wr(8'h64, 16'h0404 | 16'(c << 4));
      settle();
      cmp(32'(ana.ref_div), 32'(c + 1));
    end
  endtask

  // Partial lane writes touch only the enabled byte
  task automatic byte_lanes();
    wr(8'h64, 16'h0404);
    bus(1'b1, 8'h64, 16'hffff, 4'h2);
    rchk(8'h64, 16'hff04);
    bus(1'b1, 8'h64, 16'h0000, 4'h1);
    rchk(8'h64, 16'hff00);
    settle();
    cmp(32'(ana.fb_div), 32'h0000_00fe);
  endtask

  // Each power-down bit alone, coarse tuning at all ones
  task automatic power_bits();
    for (int b = 4; b < 8; b++) begin
      wr(8'h68, 16'hfc00 | 16'(1 << b));
      rchk(8'h68, 16'hfc00 | 16'(1 << b));
      settle();
      cmp(32'(ana.vco_coarse), 32'h0000_003f);
      cmp(32'({ana.bias_sleep, ana.tsense_sleep, ana.mult_sleep, ana.clkrx_sleep}), 32'(1 << (b - 4)));
      cmp(32'({ana.clkrx_sleep, ana.output_strobe_input_sleep}), {30'h0, {2{b == 4}}});
    end
    wr(8'h68, 16'hffff);
    rchk(8'h68, 16'hfcf0);
  endtask

  task automatic ref_fuse();
    wr(8'h6c, 16'hffff);
    rchk(8'h6c, 16'h8800);
    settle();
    cmp(32'({ana.extref_sel, ana.fuse_sleep}), 32'h0000_0003);
    wr(8'h6c, 16'h0800);
    settle();
    cmp(32'({ana.extref_sel, ana.fuse_sleep}), 32'h0000_0001);
  endtask

  // Reserved and unmapped places swallow writes and read zero
  task automatic reserved_regs();
    logic [7:0] a[3] = '{8'h70, 8'h74, 8'h7c};
    for (int i = 0; i < 3; i++) begin
      wr(a[i], 16'hffff);
      rchk(a[i], 16'h0000);
    end
  endtask

  task automatic mult_route();
    wr(8'hc0, 16'hffff);
    rchk(8'hc0, 16'h0400);
    settle();
    cmp(32'(ana.mult_route), 32'h0000_0001);
    wr(8'hc0, 16'h0000);
    settle();
    cmp(32'(ana.mult_route), 32'h0000_0000);
  endtask

  // Main sequence, with a second reset after the last test, then the reset values again
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    reset_values();
    feedback_modes();
    ref_divider();
    byte_lanes();
    power_bits();
    ref_fuse();
    reserved_regs();
    mult_route();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    reset_values();
    tally_and_finish();
  end
endmodule
